// File: logic/pin_mux_pkg.sv
// Constants, field layouts and carrier types for the control-pin mux.
// Assumes a 32-bit classic Wishbone slave port on the device clock.
//
// Notes on behaviour
// R1: Strap low selects general-purpose I/O on pin A
// R2: Strap high selects write strobe on pin A
// R3: Function fixed when reset releases
// R4: General-purpose pin A starts as input
// R5: Strobe floats in reset, then drives 1
// R6: One strobe serves all memory types
// R7: Strap picks ready input or I/O on B
// R8: General-purpose pin B starts as input
// R9: Far device drives ready high when done
// R10: Ready low stretches access one cycle, repeat
// R11: Ready pull-up, default on, software disables
// R12: Control pins float during bus hold
// R13: Clock-float bit decides output clock in hold
// R14: Control pins float in off mode
// R15: Bus holder per pin, default on, switchable
// R16: Reset-float pins float while reset low
// R17: Software sets general-purpose direction per pin
// R18: Selection held until the next reset
package pin_mux_pkg;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_BUS_CTRL = 8'h00;
	localparam logic [7:0] ADDR_GLOBAL_1 = 8'h04;
	localparam logic [7:0] ADDR_GLOBAL_2 = 8'h08;
	localparam logic [7:0] ADDR_GP_DIR = 8'h0C;
	localparam logic [7:0] ADDR_GP_OUT = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int BIT_READY_PULLUP = 0;
	localparam int BIT_HOLDER_A = 1;
	localparam int BIT_HOLDER_B = 2;
	localparam int BIT_CLK_HIZ = 0;
	localparam int BIT_PIN_A = 0;
	localparam int BIT_PIN_B = 1;
	localparam int BIT_ST_FUNC = 2;
	localparam int BIT_ST_HOLD = 3;
	localparam int BIT_ST_OFF = 4;
	localparam int BIT_ST_WAIT = 5;
	localparam logic [2:0] BUS_CTRL_RESET = 3'h7;
	localparam logic [1:0] GP_DIR_RESET = 2'h0;
	localparam logic [1:0] GP_OUT_RESET = 2'h0;
	localparam logic CLK_HIZ_RESET = 1'h0;
	localparam logic STROBE_IDLE = 1'h1;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic {
		FUNC_GP = 1'b0,
		FUNC_MEM = 1'b1
	} pin_func_type;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_STROBE = 2'b01,
		ACC_WAIT = 2'b10
	} access_state_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} wb_req_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_type;

	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_type;

endpackage

// File: logic/parallel_port_ctrl_pin_mux.sv
// Function selection and pad control for two parallel-port control pins.
// Assumes pads resolve o/oe into the wire and apply the pull and holder
// enables; the memory-interface core runs on the same clock.
`timescale 1ns/1ps
module parallel_port_ctrl_pin_mux (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire pin_mux_pkg::wb_req_type wb_req,
	output pin_mux_pkg::wb_rsp_type wb_rsp,
	input wire logic function_strap,
	input wire logic ctrl_pin_a_in,
	output pin_mux_pkg::pin_drive_type ctrl_pin_a,
	input wire logic ctrl_pin_b_in,
	output pin_mux_pkg::pin_drive_type ctrl_pin_b,
	output logic ready_pullup_en,
	output logic holder_a_en,
	output logic holder_b_en,
	input wire logic hold_req,
	output logic hold_ack,
	input wire logic test_reset,
	input wire logic emulation_pin_0,
	input wire logic emulation_off_pin,
	output pin_mux_pkg::pin_drive_type mem_clock_out_1,
	output pin_mux_pkg::pin_drive_type mem_clock_out_2,
	input wire logic access_start,
	input wire logic access_write,
	input wire logic access_end,
	output logic access_wait,
	output logic access_done,
	output pin_mux_pkg::pin_func_type pin_function
);
	import pin_mux_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Pin may only drive when neither hold nor off mode floats it
	function automatic logic drive_allowed(input logic hold_on,
		input logic off_on);
		drive_allowed = !hold_on && !off_on;
	endfunction

	// Byte-lane gated write of a low-byte field
	function automatic logic lane0_write(input wb_req_type r,
		input logic [7:0] addr);
		lane0_write = r.cyc && r.stb && r.we && r.sel[0] &&
			(r.adr == addr);
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] strap_sync;
	logic [1:0] pin_a_sync;
	logic [1:0] pin_b_sync;
	logic [1:0] hold_sync;
	logic [1:0] trst_sync;
	logic [1:0] emulation_pin_0_sync;
	logic [1:0] emu1_sync;

	// Two stages for every asynchronous pin; first stage feeds only the
	// second so metastability never reaches decode logic
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			strap_sync <= {strap_sync[0], function_strap};
			pin_a_sync <= {pin_a_sync[0], ctrl_pin_a_in};
			pin_b_sync <= {pin_b_sync[0], ctrl_pin_b_in};
			hold_sync <= {hold_sync[0], hold_req};
			trst_sync <= {trst_sync[0], test_reset};
			emulation_pin_0_sync <= {emulation_pin_0_sync[0], emulation_pin_0};
			emu1_sync <= {emu1_sync[0], emulation_off_pin};
		end
	end

	// ------------------------------------------------------------------
	// Function selection
	// ------------------------------------------------------------------
	pin_func_type func_sel;

	// Strap follows the pin throughout reset; the last value seen before
	// release is kept until the next reset
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			func_sel <= strap_sync[1] ? FUNC_MEM : FUNC_GP; // see R1 R2 R7
		end
	end // see R3 R18: no load while rst_n is high

	logic mem_mode;
	assign mem_mode = (func_sel == FUNC_MEM);

	// ------------------------------------------------------------------
	// Bus hold and off mode
	// ------------------------------------------------------------------
	logic off_mode;
	// Off needs test reset 0, first emulation pin 1, off-select pin 0
	assign off_mode = !trst_sync[1] && emulation_pin_0_sync[1] && !emu1_sync[1];

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [2:0] bus_ctrl;
	logic clk_hiz_1;
	logic clk_hiz_2;
	logic [1:0] gp_dir;
	logic [1:0] gp_out;
	logic bus_take;

	// A write lands on the edge where ack is already high, matching the
	// master's sampling edge
	assign bus_take = wb_rsp.ack && wb_req.cyc && wb_req.stb;

	// Pull-up and holder enables, all on out of reset
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			bus_ctrl <= BUS_CTRL_RESET; // see R11 R15
		end
		else if (ce && bus_take && lane0_write(wb_req, ADDR_BUS_CTRL))
		begin
			bus_ctrl <= wb_req.dat[2:0]; // see R11 R15
		end
	end

	// Output-clock float bits for hold mode
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			clk_hiz_1 <= CLK_HIZ_RESET;
			clk_hiz_2 <= CLK_HIZ_RESET;
		end
		else if (ce && bus_take)
		begin
			if (lane0_write(wb_req, ADDR_GLOBAL_1))
			begin
				clk_hiz_1 <= wb_req.dat[BIT_CLK_HIZ];
			end
			if (lane0_write(wb_req, ADDR_GLOBAL_2))
			begin
				clk_hiz_2 <= wb_req.dat[BIT_CLK_HIZ];
			end
		end
	end

	// General-purpose direction and output value
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			gp_dir <= GP_DIR_RESET; // see R4 R8
			gp_out <= GP_OUT_RESET;
		end
		else if (ce && bus_take)
		begin
			if (lane0_write(wb_req, ADDR_GP_DIR))
			begin
				gp_dir <= wb_req.dat[1:0]; // see R17
			end
			if (lane0_write(wb_req, ADDR_GP_OUT))
			begin
				gp_out <= wb_req.dat[1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Wishbone answer
	// ------------------------------------------------------------------
	logic [31:0] next_rdata;

	// Read mux; unmapped addresses answer zero
	always_comb
	begin
		next_rdata = '0;
		case (wb_req.adr)
			ADDR_BUS_CTRL: next_rdata[2:0] = bus_ctrl;
			ADDR_GLOBAL_1: next_rdata[BIT_CLK_HIZ] = clk_hiz_1;
			ADDR_GLOBAL_2: next_rdata[BIT_CLK_HIZ] = clk_hiz_2;
			ADDR_GP_DIR: next_rdata[1:0] = gp_dir;
			ADDR_GP_OUT: next_rdata[1:0] = gp_out;
			ADDR_STATUS:
			begin
				next_rdata[BIT_PIN_A] = pin_a_sync[1];
				next_rdata[BIT_PIN_B] = pin_b_sync[1];
				next_rdata[BIT_ST_FUNC] = mem_mode;
				next_rdata[BIT_ST_HOLD] = hold_ack;
				next_rdata[BIT_ST_OFF] = off_mode;
				next_rdata[BIT_ST_WAIT] = access_wait;
			end
			default: next_rdata = '0;
		endcase
	end

	// One-cycle answer; ack drops for a cycle between requests
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			wb_rsp <= '0;
		end
		else if (ce)
		begin
			wb_rsp.ack <= wb_req.cyc && wb_req.stb && !wb_rsp.ack;
			wb_rsp.dat <= next_rdata;
		end
	end

	// ------------------------------------------------------------------
	// Memory access wait extension
	// ------------------------------------------------------------------
	access_state_type acc_state;
	logic ready_level;
	logic write_active;

	// An unselected ready pin never stalls, like the pull-up on a bare pin
	assign ready_level = mem_mode ? pin_b_sync[1] : 1'b1;

	// Ready is sampled at the nominal end and on every stretched cycle;
	// the far side raising ready is what ends a stretch
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			acc_state <= ACC_IDLE;
			write_active <= 1'b0;
			access_wait <= 1'b0;
			access_done <= 1'b0;
		end
		else if (ce)
		begin
			access_done <= 1'b0;
			case (acc_state)
				ACC_IDLE:
				begin
					if (access_start && mem_mode)
					begin
						acc_state <= ACC_STROBE;
						write_active <= access_write; // see R6
					end
				end
				ACC_STROBE:
				begin
					if (access_end && !ready_level)
					begin
						acc_state <= ACC_WAIT; // see R10 R9
						access_wait <= 1'b1;
					end
					else if (access_end)
					begin
						acc_state <= ACC_IDLE;
						write_active <= 1'b0;
						access_done <= 1'b1;
					end
				end
				ACC_WAIT:
				begin
					if (ready_level)
					begin
						acc_state <= ACC_IDLE; // see R10
						write_active <= 1'b0;
						access_wait <= 1'b0;
						access_done <= 1'b1;
					end
				end
				default:
				begin
					acc_state <= ACC_IDLE;
					write_active <= 1'b0;
					access_wait <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	logic drive_ok;
	assign drive_ok = drive_allowed(hold_ack, off_mode); // see R12 R14

	// Reset floats both pins; the strobe sits at its idle 1 afterwards
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			ctrl_pin_a <= '{o: STROBE_IDLE, oe: 1'b0}; // see R5 R16
			ctrl_pin_b <= '{o: 1'b0, oe: 1'b0}; // see R16
		end
		else if (ce)
		begin
			if (mem_mode)
			begin
				// Strobe low while a write holds it, also when stretched
				ctrl_pin_a.o <= !write_active; // see R5 R6
				ctrl_pin_a.oe <= drive_ok; // see R12 R14
				ctrl_pin_b.o <= 1'b0;
				ctrl_pin_b.oe <= 1'b0; // see R7
			end
			else
			begin
				ctrl_pin_a.o <= gp_out[BIT_PIN_A];
				ctrl_pin_a.oe <= gp_dir[BIT_PIN_A] && drive_ok; // see R17
				ctrl_pin_b.o <= gp_out[BIT_PIN_B];
				ctrl_pin_b.oe <= gp_dir[BIT_PIN_B] && drive_ok; // see R17
			end
		end
	end

	// Pad enables and hold acknowledge; hold waits for a running access to end,
	// but an access starting in the grant cycle or during hold has its strobe floated
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			ready_pullup_en <= BUS_CTRL_RESET[BIT_READY_PULLUP];
			holder_a_en <= BUS_CTRL_RESET[BIT_HOLDER_A];
			holder_b_en <= BUS_CTRL_RESET[BIT_HOLDER_B];
			hold_ack <= 1'b0;
		end
		else if (ce)
		begin
			ready_pullup_en <= bus_ctrl[BIT_READY_PULLUP]; // see R11
			holder_a_en <= bus_ctrl[BIT_HOLDER_A]; // see R15
			holder_b_en <= bus_ctrl[BIT_HOLDER_B]; // see R15
			if (!hold_sync[1])
			begin
				hold_ack <= 1'b0;
			end
			else if (acc_state == ACC_IDLE)
			begin
				hold_ack <= 1'b1; // see R12
			end
		end
	end

	// ------------------------------------------------------------------
	// Memory output clocks
	// ------------------------------------------------------------------
	logic clk_phase;

	// Half-rate clocks; in hold each floats only when its bit is 1
	always_ff @(posedge clk)
	begin
		if (ce && !rst_n)
		begin
			clk_phase <= 1'b0;
			mem_clock_out_1 <= '0;
			mem_clock_out_2 <= '0;
		end
		else if (ce)
		begin
			clk_phase <= !clk_phase;
			mem_clock_out_1.o <= !clk_phase;
			mem_clock_out_2.o <= !clk_phase;
			mem_clock_out_1.oe <= !(hold_ack && clk_hiz_1) && !off_mode; // see R13
			mem_clock_out_2.oe <= !(hold_ack && clk_hiz_2) && !off_mode; // see R13
		end
	end

	// ------------------------------------------------------------------
	// Selection report
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			pin_function <= func_sel;
		end
	end

endmodule // parallel_port_ctrl_pin_mux

// File: testbench/pin_mux_props.sv
// Checker for the control-pin mux, on the top module's ports.
// Assumes the clock enable stays high while it watches.
`timescale 1ns/1ps
module pin_mux_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire pin_mux_pkg::pin_drive_type ctrl_pin_a,
	input wire pin_mux_pkg::pin_drive_type ctrl_pin_b,
	input wire logic ctrl_pin_b_in,
	input wire logic ready_pullup_en,
	input wire logic holder_a_en,
	input wire logic holder_b_en,
	input wire logic hold_ack,
	input wire logic test_reset,
	input wire logic emulation_pin_0,
	input wire logic emulation_off_pin,
	input wire pin_mux_pkg::pin_drive_type mem_clock_out_1,
	input wire logic access_start,
	input wire logic access_write,
	input wire logic access_wait,
	input wire logic access_done,
	input wire pin_mux_pkg::pin_func_type pin_function
);
	import pin_mux_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RESET_FLOAT: assert property ($rose(rst_n) |->
		!ctrl_pin_a.oe && !ctrl_pin_b.oe) else $error("pad driven in reset");
	AST_ENABLES_ON: assert property ($rose(rst_n) |->
		ready_pullup_en && holder_a_en && holder_b_en) else $error("enable off");
	AST_FUNC_LOCKED: assert property ($past(rst_n) |->
		$stable(pin_function)) else $error("function moved");
	AST_GP_INPUT: assert property ($rose(rst_n) && pin_function == FUNC_GP
		|=> !ctrl_pin_a.oe && !ctrl_pin_b.oe) else $error("gp pin not input");
	AST_STROBE_IDLE: assert property ($rose(rst_n) && pin_function == FUNC_MEM
		|-> ##[1:3] ctrl_pin_a.oe && ctrl_pin_a.o) else $error("strobe not idle");
	AST_READY_INPUT: assert property (pin_function == FUNC_MEM |->
		!ctrl_pin_b.oe) else $error("ready pin driven");
	AST_WRITE_STROBE: assert property (access_start && access_write &&
		pin_function == FUNC_MEM && !access_wait && !hold_ack |->
		##2 !ctrl_pin_a.o) else $error("strobe not low");
	AST_WAIT_HOLDS: assert property (access_wait && !ctrl_pin_b_in &&
		!$past(ctrl_pin_b_in) && !$past(ctrl_pin_b_in, 2) |=>
		access_wait && !access_done) else $error("stretch ended early");
	AST_HOLD_FLOAT: assert property (hold_ack && $past(hold_ack) |->
		!ctrl_pin_a.oe && !ctrl_pin_b.oe) else $error("pad driven in hold");
	AST_CLK_TOGGLE: assert property (mem_clock_out_1.oe &&
		$past(mem_clock_out_1.oe) |-> mem_clock_out_1.o !=
		$past(mem_clock_out_1.o)) else $error("clock stopped");
	AST_OFF_FLOAT: assert property ((!test_reset && emulation_pin_0 &&
		!emulation_off_pin) [*4] |-> !ctrl_pin_a.oe && !mem_clock_out_1.oe)
		else $error("pad driven in off mode");
endmodule // pin_mux_props
bind parallel_port_ctrl_pin_mux pin_mux_props u_pin_mux_props (.*);

// File: testbench/mem_ready_model.sv
// Far-side memory: answers the write strobe on the ready wire.
// Assumes the bench resolves ready onto pin B in memory mode.
`timescale 1ns/1ps
module mem_ready_model (
	input wire logic clk,
	input wire logic strobe_n,
	input wire logic [3:0] wait_len,
	output logic ready
);
	logic [3:0] left = 4'h0;
	logic seen = 1'b0;
	// Low while it needs more time, high when it can finish
	assign ready = (left == 4'h0);
	// Start the stretch count on each falling strobe
	always_ff @(posedge clk)
	begin
		seen <= !strobe_n;
		if (!strobe_n && !seen)
			left <= wait_len;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
endmodule // mem_ready_model

// File: testbench/parallel_port_ctrl_pin_mux_tb.sv
// Self-checking bench for the control-pin mux.
// Assumes the ready model and checker are compiled first.
`timescale 1ns/1ps
module parallel_port_ctrl_pin_mux_tb;
	import pin_mux_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	wb_req_type wb_req = '0;
	wb_rsp_type wb_rsp;
	logic function_strap = 1'b0;
	logic ctrl_pin_a_in;
	logic ctrl_pin_b_in;
	pin_drive_type ctrl_pin_a;
	pin_drive_type ctrl_pin_b;
	logic ready_pullup_en;
	logic holder_a_en;
	logic holder_b_en;
	logic hold_req = 1'b0;
	logic hold_ack;
	logic test_reset = 1'b1;
	logic emulation_pin_0 = 1'b0;
	logic emulation_off_pin = 1'b1;
	pin_drive_type mem_clock_out_1;
	pin_drive_type mem_clock_out_2;
	logic access_start = 1'b0;
	logic access_write = 1'b0;
	logic access_end = 1'b0;
	logic access_wait;
	logic access_done;
	pin_func_type pin_function;
	logic [1:0] pad_drv = 2'h0;
	logic [1:0] r;
	logic [1:0] p;
	logic mem_mode = 1'b0;
	logic [3:0] wait_len = 4'h0;
	logic ready;
	logic [31:0] exp_q[$];
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	// Pad wires: a driving pad wins, else the far side
	assign ctrl_pin_a_in = ctrl_pin_a.oe ? ctrl_pin_a.o : pad_drv[0];
	assign ctrl_pin_b_in = ctrl_pin_b.oe ? ctrl_pin_b.o :
		(mem_mode ? ready : pad_drv[1]);
	always #12.5 clk = ~clk;
	parallel_port_ctrl_pin_mux u_parallel_port_ctrl_pin_mux (.*);
	mem_ready_model u_mem_ready_model (.clk(clk), .wait_len(wait_len),
		.strobe_n(ctrl_pin_a.oe ? ctrl_pin_a.o : 1'b1), .ready(ready));
	task automatic cmp_read(input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR read data expected %h seen %h", e, g);
		end
	endtask
	task automatic cmp_pin(input string s, input logic [2:0] e,
		input logic [2:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", s, e, g);
		end
	endtask
	task automatic final_report();
		// A read note never met by an answer is a lost result
		if (exp_q.size() != 0)
		begin
			fail_count++;
			$display("ERROR read queue expected 0 seen %0d", exp_q.size());
		end
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Classic cycle: hold until ack is sampled, then idle one cycle;
	// only the bench timeout ends a wait for ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
		@(posedge clk);
		while (wb_rsp.ack !== 1'b1)
		begin
			@(posedge clk);
		end
		wb_req <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask
	// Strap moves right after release, which must not matter
	task automatic do_reset(input logic s);
		mem_mode <= s;
		function_strap <= s;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		function_strap <= ~s;
		repeat (5) @(posedge clk);
	endtask
	task automatic access(input logic [3:0] wl, input logic w);
		logic saw = 1'b0;
		wait_len <= wl;
		access_start <= 1'b1;
		access_write <= w;
		@(posedge clk);
		access_start <= 1'b0;
		repeat (2) @(posedge clk);
		cmp_pin("strobe level", {2'h0, ~w}, {2'h0, ctrl_pin_a.o});
		repeat (4) @(posedge clk);
		access_end <= 1'b1;
		@(posedge clk);
		access_end <= 1'b0;
		while (access_done !== 1'b1)
		begin
			saw |= (access_wait === 1'b1);
			@(posedge clk);
		end
		cmp_pin("stretch", {2'h0, wl != 4'h0}, {2'h0, saw});
		repeat (3) @(posedge clk);
		cmp_pin("strobe idle", 3'h1, {2'h0, ctrl_pin_a.o});
	endtask
	// Read results meet their notes in issue order
	always @(posedge clk)
		if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0)
			cmp_read(exp_q.pop_front(), wb_rsp.dat);
	// A hang counts as a mismatch
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			final_report();
		end
	end
	initial
	begin
		void'($urandom(91));
		do_reset(1'b0);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_BUS_CTRL, {29'h0, BUS_CTRL_RESET});
		rd(8'h40, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			r = 2'($urandom);
			p = 2'($urandom);
			pad_drv <= p;
			wb(1'b1, ADDR_GP_OUT, {30'h0, r});
			wb(1'b1, ADDR_GP_DIR, i);
			repeat (4) @(posedge clk);
			rd(ADDR_STATUS, {30'h0, (i[1:0] & r) | (~i[1:0] & p)});
		end
		wb(1'b1, ADDR_BUS_CTRL, 32'h0);
		rd(ADDR_BUS_CTRL, 32'h0);
		cmp_pin("enables", 3'h0, {ready_pullup_en, holder_a_en, holder_b_en});
		$display("test gp done");
		do_reset(1'b1);
		rd(ADDR_STATUS, 32'h7);
		access(4'h0, 1'b1);
		access(4'h8, 1'b1);
		access(4'hC, 1'b1);
		access(4'h0, 1'b0);
		rd(ADDR_STATUS, 32'h7);
		$display("test access done");
		wb(1'b1, ADDR_GLOBAL_1, 32'h1);
		hold_req <= 1'b1;
		while (hold_ack !== 1'b1)
		begin
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
		cmp_pin("hold pads", 3'h1, {ctrl_pin_a.oe, mem_clock_out_1.oe, mem_clock_out_2.oe});
		hold_req <= 1'b0;
		test_reset <= 1'b0;
		emulation_pin_0 <= 1'b1;
		emulation_off_pin <= 1'b0;
		repeat (8) @(posedge clk);
		cmp_pin("off pads", 3'h0, {ctrl_pin_a.oe, ctrl_pin_b.oe, mem_clock_out_2.oe});
		$display("test hold off done");
		final_report();
	end
endmodule // parallel_port_ctrl_pin_mux_tb
